/* File: hw/erase_block_map.sv */
// Maps a flash address onto its erase block and grants erase only for the selected one
`timescale 1ns/1ps
`default_nettype none
`include "flash_regs_consts.svh"
module erase_block_map (
    erase_map_if.map em
);
    localparam logic [16*`NUM_BLOCKS-1:0] LO = `BLK_LO;
    localparam logic [16*`NUM_BLOCKS-1:0] HI = `BLK_HI;
    logic [`NUM_BLOCKS-1:0] in_block;

    // ****************************************
    // Block address ranges
    // ****************************************
    for (genvar i = 0; i < `NUM_BLOCKS; i++) begin : g_blk
        assign in_block[i] = (em.target_addr >= LO[16*i +: 16])
            && (em.target_addr <= HI[16*i +: 16]);
    end

    // Unselected blocks and addresses outside every block stay erase-protected
    assign em.permit = |(in_block & em.block_sel);
endmodule : erase_block_map
`default_nettype wire

/* File: hw/flash_program_erase_control_regs.sv */
// Flash program/erase control and status registers on the internal byte bus
`timescale 1ns/1ps
`default_nettype none
`include "flash_regs_consts.svh"
// Operation
// - Sticky error flag, reset-only clear, forces protection
// - Reserved bits read zero, writes ignored
// - Erase setup sets only with pin and software enable
// - Program setup sets only with pin and software enable
// - Block select bits six to zero writable
// - Block select clears on reset, standby, protection
// - Only the selected block may be erased
// - Seven-block address map of the flash
// - Mode monitor reflects the two test pins
// - Register select control resets to zero
// - Select bit maps control registers into window
// - Deselected control registers keep their contents
// - Setup bits clear in standby and protection
// - Software enable writable only with pin flag
// - Second control register resets to zero
// - Byte-wide accesses taking two states
module flash_program_erase_control_regs (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic bus_req,
    input wire logic bus_we,
    input wire flash_regs_pkg::addr_t bus_addr,
    input wire flash_regs_pkg::byte_t bus_wdata,
    output flash_regs_pkg::byte_t bus_rdata,
    output logic bus_ack,
    input wire logic write_enable_pin,
    input wire logic second_mode_pin,
    input wire logic first_mode_pin,
    input wire logic standby,
    input wire logic flash_error,
    input wire flash_regs_pkg::addr_t erase_addr,
    output logic erase_mode,
    output logic program_mode,
    output logic erase_verify_mode,
    output logic program_verify_mode,
    output logic erase_permit,
    output logic error_protect
);
    import flash_regs_pkg::*;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [2:0] pin_meta;
    logic write_enable_pin_flag;
    logic test_pin_two_monitor;
    logic test_pin_one_monitor;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pin_meta <= 3'h0;
            write_enable_pin_flag <= 1'b0;
            test_pin_two_monitor <= 1'b0;
            test_pin_one_monitor <= 1'b0;
        end else begin
            pin_meta <= {write_enable_pin, second_mode_pin, first_mode_pin};
            write_enable_pin_flag <= pin_meta[2];
            test_pin_two_monitor <= pin_meta[1];
            test_pin_one_monitor <= pin_meta[0];
        end
    end

    // ****************************************
    // Address decode
    // ****************************************
    logic software_write_enable;
    logic erase_setup_bit;
    logic program_setup_bit;
    logic program_erase_error_flag;
    logic [6:0] erase_block_select;
    logic flash_register_select_bit;
    reg_off_t off;
    logic wr;
    logic any_protect;

    // Window registers vanish from the map while the select bit is low
    function automatic reg_off_t decode(input addr_t a, input logic sel);
        if (sel && a == `ADDR_CTRL_FIRST) return OFF_CTRL_FIRST;
        if (sel && a == `ADDR_CTRL_SECOND) return OFF_CTRL_SECOND;
        if (sel && a == `ADDR_BLOCK_SEL) return OFF_BLOCK_SEL;
        if (a == `ADDR_MODE_MON) return OFF_MODE_MON;
        if (a == `ADDR_REG_SEL_CTRL) return OFF_REG_SEL;
        return OFF_NONE;
    endfunction : decode

    assign off = decode(bus_addr, flash_register_select_bit);
    assign wr = bus_req && bus_we;
    // Hardware protect (pin low), software protect (enable low) or standby
    assign any_protect = !write_enable_pin_flag || !software_write_enable || standby;

    // ****************************************
    // First control register
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !write_enable_pin_flag || standby) begin
            software_write_enable <= 1'b0;
        end else if (wr && off == OFF_CTRL_FIRST) begin
            software_write_enable <= bus_wdata[`BIT_SW_WE];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n || any_protect) begin
            erase_verify_mode <= 1'b0;
            program_verify_mode <= 1'b0;
        end else if (wr && off == OFF_CTRL_FIRST) begin
            erase_verify_mode <= bus_wdata[`BIT_ERASE_VERIFY];
            program_verify_mode <= bus_wdata[`BIT_PROG_VERIFY];
        end
    end

    // Go bits also drop under error protection so a failed operation stops at once
    always_ff @(posedge ref_clk) begin
        if (!rst_n || any_protect || program_erase_error_flag) begin
            erase_mode <= 1'b0;
            program_mode <= 1'b0;
        end else if (wr && off == OFF_CTRL_FIRST) begin
            erase_mode <= bus_wdata[`BIT_ERASE_GO] && erase_setup_bit;
            program_mode <= bus_wdata[`BIT_PROG_GO] && program_setup_bit;
        end
    end

    // ****************************************
    // Second control register
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_n || any_protect || program_erase_error_flag) begin
            erase_setup_bit <= 1'b0;
            program_setup_bit <= 1'b0;
        end else if (wr && off == OFF_CTRL_SECOND) begin
            erase_setup_bit <= bus_wdata[`BIT_ERASE_SETUP];
            program_setup_bit <= bus_wdata[`BIT_PROG_SETUP];
        end
    end

    // Not cleared by standby: only a chip reset leaves error protection
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            program_erase_error_flag <= 1'b0;
        end else if (flash_error && (erase_mode || program_mode)) begin
            program_erase_error_flag <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            error_protect <= 1'b0;
        end else begin
            error_protect <= program_erase_error_flag;
        end
    end

    // ****************************************
    // Block select and erase map
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_n || any_protect) begin
            erase_block_select <= 7'h00;
        end else if (wr && off == OFF_BLOCK_SEL) begin
            erase_block_select <= bus_wdata[6:0];
        end
    end

    erase_map_if em ();
    assign em.block_sel = erase_block_select;
    assign em.target_addr = erase_addr;
    erase_block_map u_map (.em(em));

    // More than one select bit is the caller's error; the map then allows any of them
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            erase_permit <= 1'b0;
        end else begin
            erase_permit <= em.permit && erase_mode;
        end
    end

    // ****************************************
    // Register select control
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            flash_register_select_bit <= 1'b0;
        end else if (wr && off == OFF_REG_SEL) begin
            flash_register_select_bit <= bus_wdata[`BIT_REG_SELECT];
        end
    end

    // ****************************************
    // Read path, answered in the second state
    // ****************************************
    byte_t next_rdata;

    always_comb begin
        next_rdata = `RESET_BYTE;
        case (off)
            OFF_CTRL_FIRST: begin
                next_rdata[`BIT_PIN_FLAG] = write_enable_pin_flag;
                next_rdata[`BIT_SW_WE] = software_write_enable;
                next_rdata[`BIT_ERASE_VERIFY] = erase_verify_mode;
                next_rdata[`BIT_PROG_VERIFY] = program_verify_mode;
                next_rdata[`BIT_ERASE_GO] = erase_mode;
                next_rdata[`BIT_PROG_GO] = program_mode;
            end
            OFF_CTRL_SECOND: begin
                next_rdata[`BIT_ERROR_FLAG] = program_erase_error_flag;
                next_rdata[`BIT_ERASE_SETUP] = erase_setup_bit;
                next_rdata[`BIT_PROG_SETUP] = program_setup_bit;
            end
            OFF_BLOCK_SEL: next_rdata[6:0] = erase_block_select;
            OFF_MODE_MON: next_rdata[1:0] = {test_pin_two_monitor, test_pin_one_monitor};
            OFF_REG_SEL: next_rdata[`BIT_REG_SELECT] = flash_register_select_bit;
            default: next_rdata = `RESET_BYTE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bus_ack <= 1'b0;
            bus_rdata <= `RESET_BYTE;
        end else begin
            bus_ack <= bus_req;
            bus_rdata <= (bus_req && !bus_we) ? next_rdata : `RESET_BYTE;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    a_error_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
        program_erase_error_flag |=> program_erase_error_flag ##1 error_protect)
        else $error("error flag dropped without reset");
    a_erase_setup_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(erase_setup_bit) |-> $past(write_enable_pin_flag && software_write_enable))
        else $error("erase setup set without enables");
    a_prog_setup_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(program_setup_bit) |-> $past(write_enable_pin_flag && software_write_enable))
        else $error("program setup set without enables");
    a_block_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!write_enable_pin_flag || standby) |=> erase_block_select == 7'h00)
        else $error("block select not cleared");
    a_sel_retain: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!flash_register_select_bit && !any_protect && !program_erase_error_flag)
        |=> $stable(erase_block_select) && $stable(erase_setup_bit) && $stable(program_setup_bit))
        else $error("deselected register changed");
    a_setup_protect: assert property (@(posedge ref_clk) disable iff (!rst_n)
        any_protect |=> !erase_setup_bit && !program_setup_bit)
        else $error("setup bit survived protection");
    a_swe_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(software_write_enable) |-> $past(write_enable_pin_flag))
        else $error("software enable set without pin flag");
    a_two_state_ack: assert property (@(posedge ref_clk) disable iff (!rst_n)
        bus_req |=> bus_ack)
        else $error("access not answered in second state");
    a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (bus_req && !bus_we && off == OFF_MODE_MON) |=> bus_rdata[7:2] == 6'h00)
        else $error("reserved monitor bits not zero");
    a_erase_permit: assert property (@(posedge ref_clk) disable iff (!rst_n)
        erase_permit |-> $past(erase_block_select != 7'h00 && erase_mode))
        else $error("erase permitted without selected block");

    c_erase_go: cover property (@(posedge ref_clk) disable iff (!rst_n)
        erase_setup_bit ##[1:20] erase_mode);
    c_prog_go: cover property (@(posedge ref_clk) disable iff (!rst_n)
        program_setup_bit ##[1:20] program_mode);
    c_error: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(error_protect));
    c_permit: cover property (@(posedge ref_clk) disable iff (!rst_n) erase_permit);
endmodule : flash_program_erase_control_regs
`default_nettype wire

/* File: pkg/erase_map_if.sv */
// Carries block selection and target address to the erase map decoder
`timescale 1ns/1ps
`default_nettype none
interface erase_map_if;
    logic [6:0] block_sel;
    logic [15:0] target_addr;
    logic permit;
    modport ctrl (output block_sel, output target_addr, input permit);
    modport map (input block_sel, input target_addr, output permit);
endinterface : erase_map_if
`default_nettype wire

/* File: pkg/flash_regs_consts.svh */
// Offsets, field positions, reset values and block bounds of the flash control registers
`ifndef FLASH_REGS_CONSTS_SVH
`define FLASH_REGS_CONSTS_SVH
`define ADDR_CTRL_FIRST 16'hff80
`define ADDR_CTRL_SECOND 16'hff81
`define ADDR_BLOCK_SEL 16'hff83
`define ADDR_MODE_MON 16'hff89
`define ADDR_REG_SEL_CTRL 16'hff8f
`define WINDOW_LO 16'hff80
`define WINDOW_HI 16'hff83
`define BIT_PIN_FLAG 7
`define BIT_SW_WE 6
`define BIT_ERASE_VERIFY 3
`define BIT_PROG_VERIFY 2
`define BIT_ERASE_GO 1
`define BIT_PROG_GO 0
`define BIT_ERROR_FLAG 7
`define BIT_ERASE_SETUP 1
`define BIT_PROG_SETUP 0
`define BIT_REG_SELECT 3
`define RESET_BYTE 8'h00
`define NUM_BLOCKS 7
`define BLK_LO {16'hc000, 16'h8000, 16'h1000, 16'h0c00, 16'h0800, 16'h0400, 16'h0000}
`define BLK_HI {16'hedff, 16'hbfff, 16'h7fff, 16'h0fff, 16'h0bff, 16'h07ff, 16'h03ff}
`endif

/* File: pkg/flash_regs_pkg.sv */
// Types shared by the flash control register block
package flash_regs_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [15:0] addr_t;
    typedef enum {OFF_CTRL_FIRST, OFF_CTRL_SECOND, OFF_BLOCK_SEL, OFF_MODE_MON, OFF_REG_SEL,
        OFF_NONE} reg_off_t;
endpackage : flash_regs_pkg

/* File: verification/flash_array_model.sv */
// Behavioural flash array facing the control register block
`timescale 1ns/1ps
`default_nettype none
module flash_array_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic erase_mode,
    input wire logic program_mode,
    input wire logic fault_cmd,
    input wire flash_regs_pkg::addr_t target,
    output logic flash_error,
    output flash_regs_pkg::addr_t erase_addr
);
    import flash_regs_pkg::*;
    // Registered on the block's own clock, so the bench's falling-edge drive never races it
    always_ff @(posedge ref_clk) begin
        // A fault is only reported while an operation is running
        flash_error <= rst_n && fault_cmd && (erase_mode || program_mode);
        // Outside an erase the address is meaningless, so show a misleading one
        erase_addr <= erase_mode ? target : ~target;
    end
endmodule : flash_array_model
`default_nettype wire

/* File: verification/flash_program_erase_control_regs_tb.sv */
// Self-checking bench for the flash program/erase control registers
`timescale 1ns/1ps
`default_nettype none
`include "flash_regs_consts.svh"
module flash_program_erase_control_regs_tb;
    import flash_regs_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic bus_req = 1'b0;
    logic bus_we = 1'b0;
    addr_t bus_addr = 16'h0000;
    byte_t bus_wdata = 8'h00;
    logic we_pin = 1'b0;
    logic m2 = 1'b0;
    logic m1 = 1'b0;
    logic standby = 1'b0;
    logic fault = 1'b0;
    addr_t target = 16'h0000;
    byte_t bus_rdata;
    logic bus_ack, flash_error, erase_mode, program_mode, ev_mode, pv_mode, permit, err_prot;
    addr_t erase_addr;
    int err_total = 0;
    int checks = 0;
    int cycles = 0;
    addr_t lo [7] = '{16'h0000, 16'h0400, 16'h0800, 16'h0c00, 16'h1000, 16'h8000, 16'hc000};
    addr_t hi [7] = '{16'h03ff, 16'h07ff, 16'h0bff, 16'h0fff, 16'h7fff, 16'hbfff, 16'hedff};

    flash_program_erase_control_regs uut (.ref_clk(ref_clk), .rst_n(rst_n), .bus_req(bus_req),
        .bus_we(bus_we), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .bus_ack(bus_ack), .write_enable_pin(we_pin), .second_mode_pin(m2),
        .first_mode_pin(m1), .standby(standby), .flash_error(flash_error),
        .erase_addr(erase_addr), .erase_mode(erase_mode), .program_mode(program_mode),
        .erase_verify_mode(ev_mode), .program_verify_mode(pv_mode), .erase_permit(permit),
        .error_protect(err_prot));
    flash_array_model fam (.ref_clk(ref_clk), .rst_n(rst_n), .erase_mode(erase_mode),
        .program_mode(program_mode), .fault_cmd(fault), .target(target),
        .flash_error(flash_error), .erase_addr(erase_addr));

    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    // Hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            wrap_up();
        end
    end

    // ************************************************************
    // Bus tasks and comparison
    // ************************************************************
    task automatic chk(input byte_t seen, input byte_t exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic acc(input logic we, input addr_t a, input byte_t wd, output byte_t rd);
        @(negedge ref_clk);
        bus_req = 1'b1;
        bus_we = we;
        bus_addr = a;
        bus_wdata = wd;
        @(negedge ref_clk);
        bus_req = 1'b0;
        chk({7'h00, bus_ack}, 8'h01);
        rd = bus_rdata;
    endtask : acc
    task automatic wr(input addr_t a, input byte_t d);
        byte_t t;
        acc(1'b1, a, d, t);
    endtask : wr
    task automatic rdc(input addr_t a, input byte_t exp);
        byte_t t;
        acc(1'b0, a, 8'h00, t);
        chk(t, exp);
    endtask : rdc
    task automatic settle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : settle
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        settle(2);
        rst_n = 1'b1;
        rdc(`ADDR_REG_SEL_CTRL, 8'h00);
        rdc(`ADDR_CTRL_SECOND, 8'h00);
        wr(`ADDR_REG_SEL_CTRL, 8'hff);
        rdc(`ADDR_REG_SEL_CTRL, 8'h08);
        rdc(16'hff82, 8'h00);
        m2 = 1'b1;
        settle(4);
        rdc(`ADDR_MODE_MON, 8'h02);
        wr(`ADDR_MODE_MON, 8'hff);
        m2 = 1'b0;
        m1 = 1'b1;
        settle(4);
        rdc(`ADDR_MODE_MON, 8'h01);
        $display("test select_and_monitor done");
        wr(`ADDR_CTRL_FIRST, 8'h40);
        rdc(`ADDR_CTRL_FIRST, 8'h00);
        wr(`ADDR_CTRL_SECOND, 8'h02);
        rdc(`ADDR_CTRL_SECOND, 8'h00);
        wr(`ADDR_CTRL_SECOND, 8'h01);
        rdc(`ADDR_CTRL_SECOND, 8'h00);
        wr(`ADDR_BLOCK_SEL, 8'h7f);
        rdc(`ADDR_BLOCK_SEL, 8'h00);
        $display("test pin_low_protect done");
        we_pin = 1'b1;
        settle(4);
        rdc(`ADDR_CTRL_FIRST, 8'h80);
        wr(`ADDR_CTRL_SECOND, 8'h02);
        rdc(`ADDR_CTRL_SECOND, 8'h00);
        wr(`ADDR_CTRL_FIRST, 8'hc0);
        rdc(`ADDR_CTRL_FIRST, 8'hc0);
        wr(`ADDR_CTRL_SECOND, 8'h02);
        rdc(`ADDR_CTRL_SECOND, 8'h02);
        wr(`ADDR_BLOCK_SEL, 8'hff);
        rdc(`ADDR_BLOCK_SEL, 8'h7f);
        wr(`ADDR_CTRL_FIRST, 8'hc2);
        chk({7'h00, erase_mode}, 8'h01);
        for (int b = 0; b < 7; b++) begin
            wr(`ADDR_BLOCK_SEL, 8'h01 << b);
            target = lo[b];
            settle(3);
            chk({7'h00, permit}, 8'h01);
            target = hi[b];
            settle(3);
            chk({7'h00, permit}, 8'h01);
            target = hi[b] + 16'h0001;
            settle(3);
            chk({7'h00, permit}, 8'h00);
        end
        $display("test erase_block_map done");
        wr(`ADDR_REG_SEL_CTRL, 8'h00);
        rdc(`ADDR_BLOCK_SEL, 8'h00);
        wr(`ADDR_BLOCK_SEL, 8'h01);
        wr(`ADDR_REG_SEL_CTRL, 8'h08);
        rdc(`ADDR_BLOCK_SEL, 8'h40);
        rdc(`ADDR_CTRL_FIRST, 8'hc2);
        $display("test deselect_retain done");
        fault = 1'b1;
        settle(3);
        fault = 1'b0;
        chk({7'h00, err_prot}, 8'h01);
        chk({7'h00, erase_mode}, 8'h00);
        rdc(`ADDR_CTRL_SECOND, 8'h80);
        wr(`ADDR_CTRL_SECOND, 8'h01);
        rdc(`ADDR_CTRL_SECOND, 8'h80);
        rst_n = 1'b0;
        settle(2);
        rst_n = 1'b1;
        chk({7'h00, err_prot}, 8'h00);
        wr(`ADDR_REG_SEL_CTRL, 8'h08);
        rdc(`ADDR_CTRL_SECOND, 8'h00);
        $display("test error_protect done");
        settle(4);
        wr(`ADDR_CTRL_FIRST, 8'h40);
        wr(`ADDR_CTRL_SECOND, 8'h01);
        wr(`ADDR_CTRL_FIRST, 8'h41);
        chk({7'h00, program_mode}, 8'h01);
        wr(`ADDR_BLOCK_SEL, 8'h04);
        standby = 1'b1;
        settle(1);
        standby = 1'b0;
        chk({7'h00, program_mode}, 8'h00);
        rdc(`ADDR_CTRL_SECOND, 8'h00);
        rdc(`ADDR_BLOCK_SEL, 8'h00);
        wr(`ADDR_CTRL_FIRST, 8'h40);
        wr(`ADDR_CTRL_FIRST, 8'h48);
        chk({7'h00, ev_mode}, 8'h01);
        wr(`ADDR_CTRL_FIRST, 8'h44);
        chk({6'h00, ev_mode, pv_mode}, 8'h01);
        $display("test program_standby done");
        wrap_up();
    end
endmodule : flash_program_erase_control_regs_tb
`default_nettype wire
